// File: design/tws_slave_rx.sv
// tws_slave_rx.sv: two-wire slave receiver with an Avalon-MM register port.
// assumes: open-drain scl/sda resolved outside; i_deep_sleep from local logic.
// Functional notes
// - answer own address in upper seven bits
// - address low bit enables general call 0x00
// - write bit selects receive; read bit is not acknowledged
// - own address plus write sets flag, status
// - lost arbitration then addressed reports 0x68/0x78
// - ack enable cleared means nack next byte
// - ack enable zero ignores address, keeps monitoring
// - deep sleep still acknowledges address when enabled
// - match in sleep wakes, holds scl low
// - data register not updated while asleep
// - codes 0x60/0x80; ack enable picks next ack
// - general call acked reports 0x70
// - after 0x88 go to not-addressed state
// - start request at clear issues start when free
// - stop or restart while addressed reports 0xa0
// - general call data reports 0x90 or 0x98
`timescale 1ns/100ps
`default_nettype none
`include "tws_params.svh"
module tws_slave_rx
  import tws_pkg::*;
#(
  parameter int TIMER_W = 8
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // avalon-mm register port
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // two-wire bus pins, enables low while driving
  input wire logic i_scl,
  output logic o_scl_out,
  output logic o_scl_oe_b,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe_b,
  // power management
  input wire logic i_deep_sleep,
  output logic o_wake
);
  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  localparam int HOLD_CYC = (`TWS_T_HOLD_NS * `TWS_CLK_MHZ + 999) / 1000;
  localparam logic [TIMER_W-1:0] HOLD_MAX = TIMER_W'(HOLD_CYC);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic sda_in;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic done_reg;
  logic [31:0] rdata_reg;
  logic wr_en;
  logic flag_clr;
  logic [7:0] own_slave_address;
  logic event_flag;
  logic ack_enable;
  logic start_request;
  logic stop_request;
  logic write_collision_flag;
  logic interface_enable;
  logic event_irq_enable;
  logic [7:0] two_wire_status_reg;
  logic [7:0] two_wire_data_reg;
  tws_state_t state_reg;
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic gc_reg;
  logic ack_reg;
  logic arb_lost_reg;
  logic busy_reg;
  logic sda_drv_reg;
  logic scl_hold_reg;
  logic set_reg;
  logic [7:0] code_reg;
  logic load_reg;
  logic sto_done_reg;
  logic wake_reg;
  logic [1:0] mphase_reg;
  logic [TIMER_W-1:0] timer_reg;
  logic addressed;
  logic sla_hit;
  logic gc_hit;
  logic byte_end;

  // address and direction decode of the received first byte
  function automatic logic [1:0] addr_match(input logic [7:0] rx, input logic [7:0] own);
    logic s;
    logic g;
    s = (rx[7:1] == own[7:1]) & ~rx[0];
    g = (rx[7:1] == `TWS_GC_ADDR) & own[`TWS_AB_GCE] & ~rx[0];
    return {g, s};
  endfunction

  // ----------------------------------------------------------------
  // bus sensing
  // ----------------------------------------------------------------
  tws_bus_sense u_sense (
    .i_ref_clk (i_ref_clk),
    .i_rst_b (i_rst_b),
    .i_scl (i_scl),
    .i_sda (i_sda),
    .o_sda (sda_in),
    .o_scl_rise (scl_rise),
    .o_scl_fall (scl_fall),
    .o_start (bus_start),
    .o_stop (bus_stop)
  );

  // ----------------------------------------------------------------
  // avalon-mm slave: one wait cycle per access
  // ----------------------------------------------------------------
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~done_reg;
  assign wr_en = i_avs_write & done_reg & i_avs_byteenable[0];
  assign flag_clr = wr_en & (i_avs_address == `TWS_OFS_CTRL)
                    & i_avs_writedata[`TWS_CB_FLAG];
  assign o_avs_readdata = rdata_reg;

  // access completion toggle
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= (i_avs_read | i_avs_write) & ~done_reg;
    end
  end

  // read data captured in the waiting cycle; unmapped reads as zero
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_reg <= 32'h0;
    end else if (i_avs_read & ~done_reg) begin
      unique case (i_avs_address)
        `TWS_OFS_ADDR: rdata_reg <= {24'h0, own_slave_address};
        `TWS_OFS_CTRL: rdata_reg <= {24'h0, event_flag, ack_enable, start_request,
                                     stop_request, write_collision_flag,
                                     interface_enable, 1'b0, event_irq_enable};
        `TWS_OFS_STAT: rdata_reg <= {24'h0, two_wire_status_reg};
        `TWS_OFS_DATA: rdata_reg <= {24'h0, two_wire_data_reg};
        default: rdata_reg <= 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  // own address register
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      own_slave_address <= `TWS_RST_BYTE;
    end else if (wr_en && i_avs_address == `TWS_OFS_ADDR) begin
      own_slave_address <= i_avs_writedata[7:0];
    end
  end

  // control bits; stop request also cleared when the stop is sent
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ack_enable <= 1'b0;
      start_request <= 1'b0;
      stop_request <= 1'b0;
      interface_enable <= 1'b0;
      event_irq_enable <= 1'b0;
    end else if (wr_en && i_avs_address == `TWS_OFS_CTRL) begin
      ack_enable <= i_avs_writedata[`TWS_CB_ACK];
      start_request <= i_avs_writedata[`TWS_CB_STA];
      stop_request <= i_avs_writedata[`TWS_CB_STO];
      interface_enable <= i_avs_writedata[`TWS_CB_EN];
      event_irq_enable <= i_avs_writedata[`TWS_CB_IE];
    end else if (sto_done_reg) begin
      stop_request <= 1'b0;
    end
  end

  // event flag: a hardware set wins over a software clear
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      event_flag <= 1'b0;
    end else if (set_reg) begin
      event_flag <= 1'b1;
    end else if (flag_clr) begin
      event_flag <= 1'b0;
    end
  end

  // status code latched with each event
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      two_wire_status_reg <= `TWS_RST_STAT;
    end else if (set_reg) begin
      two_wire_status_reg <= code_reg;
    end
  end

  // data register; writes while the flag is clear collide
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      two_wire_data_reg <= `TWS_RST_BYTE;
      write_collision_flag <= 1'b0;
    end else if (load_reg) begin
      two_wire_data_reg <= shift_reg;
    end else if (wr_en && i_avs_address == `TWS_OFS_DATA) begin
      write_collision_flag <= ~event_flag;
      if (event_flag) begin
        two_wire_data_reg <= i_avs_writedata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // bus tracking and wake-up
  // ----------------------------------------------------------------
  // bus busy between start and stop
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      busy_reg <= 1'b0;
    end else if (bus_start) begin
      busy_reg <= 1'b1;
    end else if (bus_stop) begin
      busy_reg <= 1'b0;
    end
  end

  // a foreign start while our start is pending loses arbitration
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      arb_lost_reg <= 1'b0;
    end else if (bus_start && start_request && state_reg != TWS_MSTA) begin
      arb_lost_reg <= 1'b1;
    end else if (set_reg || !interface_enable) begin
      arb_lost_reg <= 1'b0;
    end
  end

  // wake request from an address match during deep sleep
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wake_reg <= 1'b0;
    end else if (state_reg == TWS_ADDR && byte_end && i_deep_sleep
                 && (sla_hit | gc_hit)) begin
      wake_reg <= 1'b1;
    end else if (flag_clr) begin
      wake_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // bus state machine
  // ----------------------------------------------------------------
  assign addressed = (state_reg == TWS_AACK) | (state_reg == TWS_DATA)
                     | (state_reg == TWS_DACK);
  assign {gc_hit, sla_hit} = addr_match(shift_reg, own_slave_address)
                             & {2{ack_enable}};
  assign byte_end = scl_fall & (bit_cnt_reg == `TWS_BITS);

  // slave receive sequence, stretch and own start/stop generation
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= TWS_IDLE;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      gc_reg <= 1'b0;
      ack_reg <= 1'b0;
      sda_drv_reg <= 1'b0;
      scl_hold_reg <= 1'b0;
      set_reg <= 1'b0;
      code_reg <= `TWS_RST_STAT;
      load_reg <= 1'b0;
      sto_done_reg <= 1'b0;
      mphase_reg <= 2'h0;
      timer_reg <= '0;
    end else begin
      set_reg <= 1'b0;
      load_reg <= 1'b0;
      sto_done_reg <= 1'b0;
      if (flag_clr && state_reg != TWS_MSTA) begin
        scl_hold_reg <= 1'b0;
      end
      if (!interface_enable) begin
        state_reg <= TWS_IDLE;
        sda_drv_reg <= 1'b0;
        scl_hold_reg <= 1'b0;
      end else if (state_reg != TWS_MSTA && (bus_stop || bus_start)) begin
        if (addressed) begin
          set_reg <= 1'b1;
          code_reg <= `TWS_ST_STOP;
        end
        state_reg <= bus_start ? TWS_ADDR : TWS_IDLE;
        bit_cnt_reg <= 4'h0;
        sda_drv_reg <= 1'b0;
      end else begin
        if (scl_rise && (state_reg == TWS_ADDR || state_reg == TWS_DATA)) begin
          shift_reg <= {shift_reg[6:0], sda_in};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
        unique case (state_reg)
          TWS_IDLE: begin
            if (start_request && !busy_reg && !event_flag) begin
              state_reg <= TWS_MSTA;
              mphase_reg <= 2'h0;
              timer_reg <= '0;
              sda_drv_reg <= 1'b1;
            end
          end
          TWS_ADDR: begin
            if (byte_end) begin
              if (sla_hit | gc_hit) begin
                gc_reg <= gc_hit & ~sla_hit;
                sda_drv_reg <= 1'b1;
                state_reg <= TWS_AACK;
              end else begin
                state_reg <= TWS_IDLE;
              end
            end
          end
          TWS_AACK: begin
            if (scl_fall) begin
              sda_drv_reg <= 1'b0;
              scl_hold_reg <= 1'b1;
              set_reg <= 1'b1;
              if (gc_reg) begin
                code_reg <= arb_lost_reg ? `TWS_ST_ARB_GC : `TWS_ST_GC;
              end else begin
                code_reg <= arb_lost_reg ? `TWS_ST_ARB_SLA : `TWS_ST_SLA_W;
              end
              bit_cnt_reg <= 4'h0;
              state_reg <= TWS_DATA;
            end
          end
          TWS_DATA: begin
            if (byte_end) begin
              ack_reg <= ack_enable;
              sda_drv_reg <= ack_enable;
              load_reg <= ~i_deep_sleep;
              state_reg <= TWS_DACK;
            end
          end
          TWS_DACK: begin
            if (scl_fall) begin
              sda_drv_reg <= 1'b0;
              scl_hold_reg <= 1'b1;
              set_reg <= 1'b1;
              if (gc_reg) begin
                code_reg <= ack_reg ? `TWS_ST_GD_ACK : `TWS_ST_GD_NACK;
              end else begin
                code_reg <= ack_reg ? `TWS_ST_D_ACK : `TWS_ST_D_NACK;
              end
              bit_cnt_reg <= 4'h0;
              state_reg <= ack_reg ? TWS_DATA : TWS_IDLE;
            end
          end
          TWS_MSTA: begin
            timer_reg <= (timer_reg == HOLD_MAX) ? '0 : timer_reg + 1'b1;
            unique case (mphase_reg)
              2'h0: if (timer_reg == HOLD_MAX) begin
                scl_hold_reg <= 1'b1; // start sent, clock held
                set_reg <= 1'b1;
                code_reg <= `TWS_ST_START;
                mphase_reg <= 2'h1;
              end
              2'h1: if (flag_clr && i_avs_writedata[`TWS_CB_STO]) begin
                scl_hold_reg <= 1'b0;
                timer_reg <= '0;
                mphase_reg <= 2'h2;
              end
              2'h2: if (timer_reg == HOLD_MAX) begin
                sda_drv_reg <= 1'b0; // stop: sda rises with scl high
                sto_done_reg <= 1'b1;
                state_reg <= TWS_IDLE;
              end
              default: mphase_reg <= 2'h0;
            endcase
          end
          default: state_reg <= TWS_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // pins and wake output
  // ----------------------------------------------------------------
  assign o_scl_out = 1'b0;
  assign o_sda_out = 1'b0;
  assign o_scl_oe_b = ~scl_hold_reg;
  assign o_sda_oe_b = ~sda_drv_reg;
  assign o_wake = wake_reg;
endmodule // tws_slave_rx
`default_nettype wire

// File: design/tws_params.svh
// tws_params.svh: offsets, field positions, reset values, status codes
// and timing figures of the two-wire slave receiver.
// assumes: included by bare name from design files.
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TWS_OFS_ADDR 4'h0
`define TWS_OFS_CTRL 4'h4
`define TWS_OFS_STAT 4'h8
`define TWS_OFS_DATA 4'hc

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TWS_CB_FLAG 7
`define TWS_CB_ACK 6
`define TWS_CB_STA 5
`define TWS_CB_STO 4
`define TWS_CB_WCOL 3
`define TWS_CB_EN 2
`define TWS_CB_IE 0
`define TWS_AB_GCE 0

// ----------------------------------------------------------------
// reset values and fixed codes
// ----------------------------------------------------------------
`define TWS_RST_BYTE 8'h00
`define TWS_RST_STAT 8'hf8
`define TWS_GC_ADDR 7'h00
`define TWS_BITS 4'h8
`define TWS_ST_START 8'h08
`define TWS_ST_SLA_W 8'h60
`define TWS_ST_ARB_SLA 8'h68
`define TWS_ST_GC 8'h70
`define TWS_ST_ARB_GC 8'h78
`define TWS_ST_D_ACK 8'h80
`define TWS_ST_D_NACK 8'h88
`define TWS_ST_GD_ACK 8'h90
`define TWS_ST_GD_NACK 8'h98
`define TWS_ST_STOP 8'ha0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TWS_CLK_MHZ 10
`define TWS_T_HOLD_NS 4000

`endif

// File: design/tws_pkg.sv
// tws_pkg.sv: types of the two-wire slave receiver.
// assumes: compiled before the design modules.
package tws_pkg;
  // one-hot bus states
  typedef enum logic [5:0] {
    TWS_IDLE = 6'b000001,
    TWS_ADDR = 6'b000010,
    TWS_AACK = 6'b000100,
    TWS_DATA = 6'b001000,
    TWS_DACK = 6'b010000,
    TWS_MSTA = 6'b100000
  } tws_state_t;
endpackage

// File: design/tws_bus_sense.sv
// tws_bus_sense.sv: synchronises the bus lines and finds edges and
// start/stop conditions.
// assumes: scl and sda come from pins outside the clock domain.
`timescale 1ns/100ps
`default_nettype none
module tws_bus_sense (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // bus pins
  input wire logic i_scl,
  input wire logic i_sda,
  // sensed events
  output logic o_sda,
  output logic o_scl_rise,
  output logic o_scl_fall,
  output logic o_start,
  output logic o_stop
);
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;

  // two-flop synchronisers, then one stage for edge detection
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], i_scl};
      sda_sync_reg <= {sda_sync_reg[0], i_sda};
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
    end
  end

  // edges and conditions seen on the settled lines
  assign o_sda = sda_sync_reg[1];
  assign o_scl_rise = scl_sync_reg[1] & ~scl_prev_reg;
  assign o_scl_fall = ~scl_sync_reg[1] & scl_prev_reg;
  assign o_start = scl_sync_reg[1] & scl_prev_reg & sda_prev_reg & ~sda_sync_reg[1];
  assign o_stop = scl_sync_reg[1] & scl_prev_reg & ~sda_prev_reg & sda_sync_reg[1];
endmodule // tws_bus_sense
`default_nettype wire

// File: bench/tws_slave_rx_asserts.sv
// tws_slave_rx_asserts.sv: port checks on tws_slave_rx, bound below.
// assumes: register offsets and control bit positions from tws_params.svh.
`timescale 1ns/100ps
`default_nettype none
`include "tws_params.svh"
module tws_slave_rx_asserts #(
  parameter int TIMER_W = 8
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // register port
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  // pin enables and wake
  input wire logic o_scl_oe_b,
  input wire logic o_sda_oe_b,
  input wire logic i_deep_sleep,
  input wire logic o_wake
);
  logic ctrl_wr, rd_acc, en_sh, ack_sh, sta_sh;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  // accepted control writes and reads
  assign ctrl_wr = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0]
    && i_avs_address == `TWS_OFS_CTRL;
  assign rd_acc = i_avs_read && !o_avs_waitrequest;
  // shadow of enable, ack and start bits as software wrote them
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      {en_sh, ack_sh, sta_sh} <= 3'b000;
    end else if (ctrl_wr) begin
      en_sh <= i_avs_writedata[`TWS_CB_EN];
      ack_sh <= i_avs_writedata[`TWS_CB_ACK];
      sta_sh <= i_avs_writedata[`TWS_CB_STA];
    end
  end
  sequence s_req;
    $rose(i_avs_read || i_avs_write);
  endsequence
  sequence s_one_wait;
    o_avs_waitrequest ##1 !o_avs_waitrequest;
  endsequence
  property p_wait;
    s_req |-> s_one_wait;
  endproperty
  property p_scl_rel;
    $rose(o_scl_oe_b) |-> $past(ctrl_wr) || $past(ctrl_wr, 2) || $past(ctrl_wr, 3);
  endproperty
  property p_wake_rise;
    $rose(o_wake) |-> i_deep_sleep || $past(i_deep_sleep);
  endproperty
  property p_wake_fall;
    $fell(o_wake) |-> $past(ctrl_wr) || $past(ctrl_wr, 2) || $past(ctrl_wr, 3);
  endproperty
  property p_sda_pull;
    $fell(o_sda_oe_b) |-> en_sh && (ack_sh || sta_sh);
  endproperty
  property p_dis;
    !en_sh [*3] |-> o_scl_oe_b && o_sda_oe_b;
  endproperty
  property p_stat_fmt;
    rd_acc && i_avs_address == `TWS_OFS_STAT |-> o_avs_readdata[2:0] == 3'h0;
  endproperty
  property p_unmapped;
    rd_acc && i_avs_address[1:0] != 2'h0 |-> o_avs_readdata == 32'h0;
  endproperty
  a_wait: assert property (p_wait) else $error("wait state count wrong");
  a_scl_rel: assert property (p_scl_rel) else $error("scl freed without clear");
  a_wake_rise: assert property (p_wake_rise) else $error("wake while awake");
  a_wake_fall: assert property (p_wake_fall) else $error("wake dropped early");
  a_sda_pull: assert property (p_sda_pull) else $error("ack while disabled");
  a_dis: assert property (p_dis) else $error("disabled unit drives bus");
  a_stat_fmt: assert property (p_stat_fmt) else $error("status low bits set");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
endmodule // tws_slave_rx_asserts
bind tws_slave_rx tws_slave_rx_asserts #(.TIMER_W(TIMER_W)) tws_slave_rx_asserts_inst (
  .i_ref_clk, .i_rst_b, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
  .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .o_scl_oe_b, .o_sda_oe_b,
  .i_deep_sleep, .o_wake
);
`default_nettype wire

// File: bench/tws_bus_master.sv
// tws_bus_master.sv: behavioural bus master transmitter, 800 ns bit time.
// assumes: bench resolves open-drain wires with pull-ups.
`timescale 1ns/100ps
`default_nettype none
module tws_bus_master (
  // clock
  input wire logic i_ref_clk,
  // resolved lines
  input wire logic i_scl,
  input wire logic i_sda,
  // drives, 1 = released
  output logic o_scl_rel,
  output logic o_sda_rel,
  // set when a stretch outlasts the bound
  output logic o_hang
);
  int n;
  initial begin
    o_scl_rel = 1'b1;
    o_sda_rel = 1'b1;
    o_hang = 1'b0;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge i_ref_clk);
  endtask
  // free scl, then honour clock stretching by the slave
  task automatic scl_up();
    o_scl_rel <= 1'b1;
    for (n = 0; n < 3000 && i_scl !== 1'b1; n++) @(negedge i_ref_clk);
    if (n == 3000) o_hang <= 1'b1;
    tick(4);
  endtask
  task automatic start_c();
    o_sda_rel <= 1'b0;
    tick(4);
    o_scl_rel <= 1'b0;
    tick(4);
  endtask
  task automatic stop_c();
    o_sda_rel <= 1'b0;
    tick(4);
    scl_up();
    o_sda_rel <= 1'b1;
    tick(8);
  endtask
  // msb first, then a ninth clock for the slave's answer
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      o_sda_rel <= b[i];
      tick(4);
      scl_up();
      o_scl_rel <= 1'b0;
    end
    o_sda_rel <= 1'b1;
    tick(4);
    scl_up();
    ack = ~i_sda;
    o_scl_rel <= 1'b0;
    tick(8);
  endtask
endmodule // tws_bus_master
`default_nettype wire

// File: bench/tb_tws_slave_rx.sv
// tb_tws_slave_rx.sv: self-checking bench of tws_slave_rx with a bus master.
// assumes: design files and tws_bus_master compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "tws_params.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_tws_slave_rx;
  logic clk, rst_b, avs_read, avs_write, waitrequest, sleep, wake, ack, gc, hang;
  logic scl, sda, m_scl, m_sda, scl_oe_b, sda_oe_b, scl_out, sda_out;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, readdata, q;
  logic [7:0] d;
  logic [6:0] own;
  int err_count, checks, seed;
  // wired-and of the open-drain lines
  assign scl = m_scl & (scl_oe_b | scl_out);
  assign sda = m_sda & (sda_oe_b | sda_out);
  tws_slave_rx tws_slave_rx_inst (
    .i_ref_clk(clk), .i_rst_b(rst_b), .i_avs_address(avs_address), .i_avs_read(avs_read),
    .i_avs_write(avs_write), .i_avs_writedata(avs_writedata), .i_avs_byteenable(4'hf),
    .o_avs_readdata(readdata), .o_avs_waitrequest(waitrequest), .i_scl(scl),
    .o_scl_out(scl_out), .o_scl_oe_b(scl_oe_b), .i_sda(sda), .o_sda_out(sda_out),
    .o_sda_oe_b(sda_oe_b), .i_deep_sleep(sleep), .o_wake(wake)
  );
  tws_bus_master tws_bus_master_inst (
    .i_ref_clk(clk), .i_scl(scl), .i_sda(sda), .o_scl_rel(m_scl), .o_sda_rel(m_sda),
    .o_hang(hang)
  );
  // verdict and end of run
  task automatic results();
    $display("checks=%0d mismatches=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one avalon access, held until waitrequest is seen low at an edge
  task automatic av(input logic wr, input logic [3:0] a, input logic [7:0] v);
    logic w;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, v};
    avs_write <= wr;
    avs_read <= ~wr;
    w = 1'b1;
    for (int n = 0; n < 50 && w; n++) begin
      @(posedge clk);
      w = waitrequest;
      q = readdata;
    end
    if (w) begin
      err_count++;
      results();
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  function automatic logic [7:0] exp_st(input logic g, input logic dat, input logic a);
    if (!dat) return g ? `TWS_ST_GC : `TWS_ST_SLA_W;
    if (g) return a ? `TWS_ST_GD_ACK : `TWS_ST_GD_NACK;
    return a ? `TWS_ST_D_ACK : `TWS_ST_D_NACK;
  endfunction
  // send a byte, check answer, flag and status (es 0: no flag)
  task automatic xfer(input logic [7:0] b, input logic ea, input logic [7:0] es);
    tws_bus_master_inst.put_byte(b, ack);
    `CHK(ack, ea)
    av(1'b0, `TWS_OFS_CTRL, 8'h00);
    `CHK(q[7], es != 8'h00)
    if (es != 8'h00) begin
      av(1'b0, `TWS_OFS_STAT, 8'h00);
      `CHK(q[7:0], es)
    end
  endtask
  // clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // watchdog, also ended by a stretch that never lets go
  initial begin
    for (int c = 0; c < 90000 && hang !== 1'b1; c++) @(posedge clk);
    err_count++;
    results();
  end
  initial begin
    seed = 32'h028ab176;
    rst_b = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    sleep = 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    av(1'b0, `TWS_OFS_STAT, 8'h00);
    `CHK(q, {24'h0, `TWS_RST_STAT})
    av(1'b0, `TWS_OFS_CTRL, 8'h00);
    `CHK(q, 32'h0)
    av(1'b0, 4'h2, 8'h00);
    `CHK(q, 32'h0)
    $display("test reset done");
    own = {2'b10, 5'($random(seed))};
    // refusals: wrong address, read bit, ack off, general call off
    for (int k = 0; k < 4; k++) begin
      av(1'b1, `TWS_OFS_ADDR, {own, k != 3});
      av(1'b1, `TWS_OFS_CTRL, (k == 2) ? 8'h04 : 8'h44);
      tws_bus_master_inst.start_c();
      xfer(k == 0 ? {~own, 1'b0} : k == 1 ? {own, 1'b1} : k == 3 ? 8'h00 : {own, 1'b0},
        1'b0, 8'h00);
      tws_bus_master_inst.stop_c();
    end
    $display("test refusals done");
    // own start on a free bus, then a stop on request
    av(1'b1, `TWS_OFS_CTRL, 8'h24);
    repeat (60) @(posedge clk);
    av(1'b0, `TWS_OFS_STAT, 8'h00);
    `CHK(q[7:0], `TWS_ST_START)
    av(1'b1, `TWS_OFS_CTRL, 8'h94);
    repeat (60) @(posedge clk);
    av(1'b0, `TWS_OFS_CTRL, 8'h00);
    `CHK(q[7:0], 8'h04)
    av(1'b1, `TWS_OFS_ADDR, {own, 1'b1});
    av(1'b1, `TWS_OFS_CTRL, 8'h44);
    for (int it = 0; it < 6; it++) begin
      gc = it[0];
      d = 8'($random(seed));
      tws_bus_master_inst.start_c();
      xfer(gc ? 8'h00 : {own, 1'b0}, 1'b1, exp_st(gc, 1'b0, 1'b1));
      av(1'b1, `TWS_OFS_CTRL, 8'hc4);
      xfer(d, 1'b1, exp_st(gc, 1'b1, 1'b1));
      av(1'b0, `TWS_OFS_DATA, 8'h00);
      `CHK(q[7:0], d)
      if (it < 3) begin
        av(1'b1, `TWS_OFS_CTRL, 8'h84);
        xfer(~d, 1'b0, exp_st(gc, 1'b1, 1'b0));
        av(1'b1, `TWS_OFS_CTRL, 8'hc4);
        xfer(8'h00, 1'b0, 8'h00);
        tws_bus_master_inst.stop_c();
      end else begin
        av(1'b1, `TWS_OFS_CTRL, 8'hc4);
        tws_bus_master_inst.stop_c();
        av(1'b0, `TWS_OFS_STAT, 8'h00);
        `CHK(q[7:0], `TWS_ST_STOP)
        av(1'b1, `TWS_OFS_CTRL, 8'hc4);
      end
    end
    // start request pending while another master holds the bus
    tws_bus_master_inst.start_c();
    xfer({~own, 1'b0}, 1'b0, 8'h00);
    av(1'b1, `TWS_OFS_CTRL, 8'h64);
    tws_bus_master_inst.scl_up();
    tws_bus_master_inst.start_c();
    xfer({own, 1'b0}, 1'b1, `TWS_ST_ARB_SLA);
    av(1'b1, `TWS_OFS_CTRL, 8'hc4);
    tws_bus_master_inst.stop_c();
    av(1'b1, `TWS_OFS_CTRL, 8'hc4);
    $display("test receive done");
    sleep <= 1'b1;
    tws_bus_master_inst.start_c();
    xfer({own, 1'b0}, 1'b1, `TWS_ST_SLA_W);
    @(negedge clk);
    `CHK(wake, 1'b1)
    `CHK(scl_oe_b, 1'b0)
    av(1'b1, `TWS_OFS_CTRL, 8'hc4);
    @(negedge clk);
    @(negedge clk);
    `CHK(wake, 1'b0)
    xfer(~d, 1'b1, `TWS_ST_D_ACK);
    av(1'b0, `TWS_OFS_DATA, 8'h00);
    `CHK(q[7:0], d)
    sleep <= 1'b0;
    av(1'b1, `TWS_OFS_CTRL, 8'hc4);
    tws_bus_master_inst.stop_c();
    av(1'b1, `TWS_OFS_CTRL, 8'hc4);
    $display("test sleep done");
    results();
  end
endmodule // tb_tws_slave_rx
`default_nettype wire
